//--- uart_host_bus_pkg.sv
package uart_host_bus_pkg;

  // register locations on the three address inputs
  localparam logic [2:0] ADDR_DATA = 3'h0; // holding regs, or divisor low with latch bit
  localparam logic [2:0] ADDR_IER = 3'h1; // interrupt enable, or divisor high
  localparam logic [2:0] ADDR_ISR = 3'h2; // read: interrupt status, write: queue control
  localparam logic [2:0] ADDR_LCR = 3'h3; // line control
  localparam logic [2:0] ADDR_MCR = 3'h4; // modem control
  localparam logic [2:0] ADDR_LSR = 3'h5; // line status
  localparam logic [2:0] ADDR_MSR = 3'h6; // modem status
  localparam logic [2:0] ADDR_SPR = 3'h7; // scratchpad

  // field positions
  localparam int LCR_DLAB = 7; // divisor latch access
  localparam int MCR_PRESCALE = 7; // 1 selects divide by 4
  localparam int QC_ENABLE = 0; // queues enabled
  localparam int QC_RX_CLR = 1; // clear receive queue
  localparam int QC_TX_CLR = 2; // clear transmit queue
  localparam int QC_DMA = 3; // legacy dma bit, no function
  localparam int QC_TX_TRIG = 4; // two bits
  localparam int QC_RX_TRIG = 6; // two bits
  localparam int IER_RX = 0; // receive interrupt enable
  localparam int IER_TX = 1; // transmit interrupt enable

  // reset values
  localparam logic [7:0] DLL_RST = 8'h01;
  localparam logic [7:0] DLM_RST = 8'h00;
  localparam logic [7:0] REG_RST = 8'h00;

  // status codes
  localparam logic [3:0] ISR_NONE = 4'h1;
  localparam logic [3:0] ISR_TX = 4'h2;
  localparam logic [3:0] ISR_RX = 4'h4;

  // queue geometry
  localparam int QDEPTH = 16;
  localparam int QPTR_W = 4;
  localparam int QCNT_W = 5;

  // prescaler and sampling
  localparam logic [1:0] PRESCALE_LAST = 2'h3; // divide by 4
  localparam logic [3:0] OVERSAMPLE_LAST = 4'hF; // 16 samples per bit

  // reset pin pulse width
  localparam int RESET_MIN_NS = 40;
  localparam int CLK_PERIOD_NS = 5;
  localparam int RESET_MIN_CYC = (RESET_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // host pins, sampled together
  typedef struct packed {
    logic cs_n;
    logic read_strobe_n;
    logic write_strobe_n;
    logic rw;
    logic bus_style;
    logic reset_pin;
    logic bus_isolate_request;
    logic [2:0] addr;
    logic [7:0] data;
  } host_pins_s;

endpackage

//--- uart_host_bus_port.sv
module uart_host_bus_port #(
  parameter logic [7:0] DEVICE_ID = 8'h5A, // arbitrary value
  parameter logic [7:0] DEVICE_REV = 8'h03 // arbitrary value
) (
  input wire logic ref_clk_i,
  input wire logic rstn_i,
  input wire uart_host_bus_pkg::host_pins_s pins_i, // raw host pins
  output logic [7:0] data_o, // host data out
  output logic data_oe_o, // high while driving host data
  output logic int_o, // interrupt pin, polarity by style
  output logic [7:0] tx_data_o, // byte to serialiser
  output logic tx_valid_o,
  input wire logic tx_ready_i,
  input wire logic [7:0] rx_data_i, // byte from deserialiser
  input wire logic rx_valid_i, // one-cycle pulse
  output logic baud_tick_o, // 16x sampling pulse
  output logic bit_tick_o // one pulse per bit time
);
  import uart_host_bus_pkg::*;

  // three-stage pin sampling
  host_pins_s s1_q, s2_q, s3_q, pin_q;
  wire host_pins_s agree = ~(s2_q ^ s3_q); // bits whose last two samples agree
  wire host_pins_s pin_d = (s2_q & agree) | (pin_q & ~agree);

  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      s1_q <= '1;
      s2_q <= '1;
      s3_q <= '1;
      pin_q <= '1;
    end else begin
      s1_q <= pins_i;
      s2_q <= s1_q;
      s3_q <= s2_q;
      pin_q <= pin_d;
    end
  end

  // bus decode on clean pins
  wire logic iso = pin_q.bus_isolate_request;
  wire logic sel = ~pin_q.cs_n & ~iso;
  wire logic rd_act = pin_q.bus_style ? sel & ~pin_q.read_strobe_n : sel & pin_q.rw;
  wire logic wr_act = pin_q.bus_style ? sel & ~pin_q.write_strobe_n : sel & ~pin_q.rw;
  wire logic soft_rst = pin_q.bus_style ? pin_q.reset_pin : ~pin_q.reset_pin;

  logic rd_q, wr_q; // previous cycle activity
  logic [2:0] waddr_q; // address held over the write
  logic [7:0] wdata_q; // data held over the write
  logic [2:0] raddr_q; // address held over the read
  wire logic wr_fall = wr_q & ~wr_act;
  wire logic rd_fall = rd_q & ~rd_act;

  // capture address and data while the cycle is open
  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      rd_q <= 1'b0;
      wr_q <= 1'b0;
      waddr_q <= 3'h0;
      wdata_q <= 8'h00;
      raddr_q <= 3'h0;
    end else begin
      rd_q <= rd_act;
      wr_q <= wr_act;
      if (wr_act) begin
        waddr_q <= pin_q.addr;
        wdata_q <= pin_q.data;
      end
      if (rd_act) begin
        raddr_q <= pin_q.addr;
      end
    end
  end

  // software registers
  logic [7:0] dll_q, dlm_q, ier_q, qc_q, lcr_q, mcr_q, spr_q;
  logic ovr_q; // overrun, cleared by status read
  wire logic dlab = lcr_q[LCR_DLAB];
  wire logic wr_dll = wr_fall & (waddr_q == ADDR_DATA) & dlab;
  wire logic wr_thr = wr_fall & (waddr_q == ADDR_DATA) & ~dlab;
  wire logic wr_qc = wr_fall & (waddr_q == ADDR_ISR);
  wire logic rd_rhr = rd_fall & (raddr_q == ADDR_DATA) & ~dlab;
  wire logic rd_lsr = rd_fall & (raddr_q == ADDR_LSR);
  wire logic q_on = qc_q[QC_ENABLE];

  // queue storage and counters
  logic [7:0] txq_q [QDEPTH];
  logic [7:0] rxq_q [QDEPTH];
  logic [QPTR_W-1:0] tx_wp_q, tx_rp_q, rx_wp_q, rx_rp_q;
  logic [QCNT_W-1:0] tx_cnt_q, rx_cnt_q;
  wire logic [QCNT_W-1:0] q_cap = q_on ? QCNT_W'(QDEPTH) : QCNT_W'(1);
  wire logic tx_push = wr_thr & (tx_cnt_q < q_cap);
  wire logic tx_pop = (tx_cnt_q != '0) & (~tx_valid_o | tx_ready_i);
  wire logic rx_push = rx_valid_i & (rx_cnt_q < q_cap);
  wire logic rx_pop = rd_rhr & (rx_cnt_q != '0);
  wire logic tx_clr = soft_rst | (wr_qc & (wdata_q[QC_TX_CLR] | (wdata_q[QC_ENABLE] != q_on)));
  wire logic rx_clr = soft_rst | (wr_qc & (wdata_q[QC_RX_CLR] | (wdata_q[QC_ENABLE] != q_on)));

  // register writes on trailing edge, defaults on either reset
  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      dll_q <= DLL_RST;
      dlm_q <= DLM_RST;
      ier_q <= REG_RST;
      qc_q <= REG_RST;
      lcr_q <= REG_RST;
      mcr_q <= REG_RST;
      spr_q <= REG_RST;
      ovr_q <= 1'b0;
    end else if (soft_rst) begin
      dll_q <= DLL_RST;
      dlm_q <= DLM_RST;
      ier_q <= REG_RST;
      qc_q <= REG_RST;
      lcr_q <= REG_RST;
      mcr_q <= REG_RST;
      spr_q <= REG_RST;
      ovr_q <= 1'b0;
    end else begin
      if (wr_dll) dll_q <= wdata_q;
      if (wr_fall & (waddr_q == ADDR_IER) & dlab) dlm_q <= wdata_q;
      if (wr_fall & (waddr_q == ADDR_IER) & ~dlab) ier_q <= wdata_q;
      // clear bits self-clear; dma bit stored but never read by logic
      if (wr_qc) qc_q <= wdata_q & ~(8'h01 << QC_RX_CLR) & ~(8'h01 << QC_TX_CLR);
      if (wr_fall & (waddr_q == ADDR_LCR)) lcr_q <= wdata_q;
      if (wr_fall & (waddr_q == ADDR_MCR)) mcr_q <= wdata_q;
      if (wr_fall & (waddr_q == ADDR_SPR)) spr_q <= wdata_q;
      // a byte lost in the clearing cycle flags only if the queue was full
      if (rx_valid_i & ~rx_push) ovr_q <= 1'b1;
      else if (rd_lsr) ovr_q <= 1'b0;
    end
  end

  // queue pointers and counts
  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      tx_wp_q <= '0;
      tx_rp_q <= '0;
      tx_cnt_q <= '0;
      rx_wp_q <= '0;
      rx_rp_q <= '0;
      rx_cnt_q <= '0;
    end else begin
      if (tx_clr) begin
        tx_wp_q <= '0;
        tx_rp_q <= '0;
        tx_cnt_q <= '0;
      end else begin
        tx_wp_q <= tx_wp_q + QPTR_W'(tx_push);
        tx_rp_q <= tx_rp_q + QPTR_W'(tx_pop);
        tx_cnt_q <= tx_cnt_q + QCNT_W'(tx_push) - QCNT_W'(tx_pop);
      end
      if (rx_clr) begin
        rx_wp_q <= '0;
        rx_rp_q <= '0;
        rx_cnt_q <= '0;
      end else begin
        rx_wp_q <= rx_wp_q + QPTR_W'(rx_push);
        rx_rp_q <= rx_rp_q + QPTR_W'(rx_pop);
        rx_cnt_q <= rx_cnt_q + QCNT_W'(rx_push) - QCNT_W'(rx_pop);
      end
    end
  end

  // queue storage, no reset needed
  always_ff @(posedge ref_clk_i) begin
    if (tx_push) txq_q[tx_wp_q] <= wdata_q;
    if (rx_push) rxq_q[rx_wp_q] <= rx_data_i;
  end

  // byte handed to the serialiser
  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      tx_valid_o <= 1'b0;
      tx_data_o <= 8'h00;
    end else if (soft_rst | tx_clr) begin
      tx_valid_o <= 1'b0;
    end else if (tx_pop) begin
      tx_valid_o <= 1'b1;
      tx_data_o <= txq_q[tx_rp_q];
    end else if (tx_ready_i) begin
      tx_valid_o <= 1'b0;
    end
  end

  // trigger level decode, only the top step differs per direction
  function automatic logic [QCNT_W-1:0] trig_level(input logic [1:0] sel2, input logic [QCNT_W-1:0] top);
    unique case (sel2)
      2'h0: trig_level = QCNT_W'(1);
      2'h1: trig_level = QCNT_W'(4);
      2'h2: trig_level = QCNT_W'(8);
      2'h3: trig_level = top;
    endcase
  endfunction

  // interrupt conditions
  wire logic [QCNT_W-1:0] tx_lvl = trig_level(qc_q[QC_TX_TRIG +: 2], QCNT_W'(12)); // tx trigger count
  wire logic [QCNT_W-1:0] rx_lvl = trig_level(qc_q[QC_RX_TRIG +: 2], QCNT_W'(14)); // rx trigger count
  wire logic tx_cond = q_on ? (tx_cnt_q < tx_lvl) : (tx_cnt_q == '0);
  wire logic rx_cond = q_on ? (rx_cnt_q >= rx_lvl) : (rx_cnt_q != '0);
  wire logic irq_rx = ier_q[IER_RX] & rx_cond;
  wire logic irq_tx = ier_q[IER_TX] & tx_cond;
  wire logic irq_lvl = irq_rx | irq_tx;
  wire logic int_d = pin_q.bus_style ? irq_lvl : ~irq_lvl;

  // read data selection
  wire logic div_zero = (dll_q == 8'h00) & (dlm_q == 8'h00);
  wire logic [3:0] isr_code = irq_rx ? ISR_RX : (irq_tx ? ISR_TX : ISR_NONE);
  wire logic [7:0] isr_val = {q_on, q_on, 2'h0, isr_code};
  wire logic [7:0] lsr_val = {1'b0, (tx_cnt_q == '0) & ~tx_valid_o, tx_cnt_q == '0, 3'h0, ovr_q, rx_cnt_q != '0};
  wire logic [7:0] rhr_val = (rx_cnt_q != '0) ? rxq_q[rx_rp_q] : 8'h00;
  wire logic [7:0] dll_val = div_zero ? DEVICE_REV : dll_q;
  wire logic [7:0] dlm_val = div_zero ? DEVICE_ID : dlm_q;
  logic [7:0] rd_mux;

  always_comb begin
    unique case (pin_q.addr)
      ADDR_DATA: rd_mux = dlab ? dll_val : rhr_val;
      ADDR_IER: rd_mux = dlab ? dlm_val : ier_q;
      ADDR_ISR: rd_mux = isr_val;
      ADDR_LCR: rd_mux = lcr_q;
      ADDR_MCR: rd_mux = mcr_q;
      ADDR_LSR: rd_mux = lsr_val;
      ADDR_MSR: rd_mux = 8'h00;
      ADDR_SPR: rd_mux = spr_q;
    endcase
  end

  // host data drive and interrupt pin
  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      data_o <= 8'h00;
      data_oe_o <= 1'b0;
      int_o <= 1'b0;
    end else begin
      data_oe_o <= rd_act;
      if (rd_act) data_o <= rd_mux;
      int_o <= int_d;
    end
  end

  // prescaler then divisor, gives the 16x sample tick
  logic [1:0] pre_q;
  logic [15:0] div_q;
  logic [3:0] os_q;
  wire logic pre_tick = ~mcr_q[MCR_PRESCALE] | (pre_q == PRESCALE_LAST);
  wire logic [15:0] divisor = {dlm_q, dll_q};
  wire logic div_hit = pre_tick & ((div_q + 16'h0001) >= divisor);

  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      pre_q <= 2'h0;
      div_q <= 16'h0000;
      os_q <= 4'h0;
      baud_tick_o <= 1'b0;
      bit_tick_o <= 1'b0;
    end else begin
      pre_q <= pre_tick ? 2'h0 : pre_q + 2'h1;
      if (pre_tick) div_q <= div_hit ? 16'h0000 : div_q + 16'h0001;
      if (div_hit) os_q <= os_q + 4'h1;
      baud_tick_o <= div_hit;
      bit_tick_o <= div_hit & (os_q == OVERSAMPLE_LAST);
    end
  end

  // checks
  property p_id_read;
    @(posedge ref_clk_i) disable iff (!rstn_i)
    rd_act & (pin_q.addr == ADDR_IER) & dlab & div_zero |=> data_o == DEVICE_ID;
  endproperty
  a_id_read: assert property (p_id_read) else $error("identity not read");
  property p_rev_read;
    @(posedge ref_clk_i) disable iff (!rstn_i)
    rd_act & (pin_q.addr == ADDR_DATA) & dlab & div_zero |=> data_o == DEVICE_REV;
  endproperty
  a_rev_read: assert property (p_rev_read) else $error("revision not read");
  property p_isolate;
    @(posedge ref_clk_i) disable iff (!rstn_i)
    iso[*2] |-> !data_oe_o && !wr_fall;
  endproperty
  a_isolate: assert property (p_isolate) else $error("bus active while isolated");
  property p_queue_bound;
    @(posedge ref_clk_i) disable iff (!rstn_i)
    tx_cnt_q <= QCNT_W'(QDEPTH) && rx_cnt_q <= QCNT_W'(QDEPTH);
  endproperty
  a_queue_bound: assert property (p_queue_bound) else $error("queue overfilled");
  property p_tx_int;
    @(posedge ref_clk_i) disable iff (!rstn_i)
    !q_on && ier_q == 8'h02 && tx_cnt_q == '0 |=> int_o == $past(pin_q.bus_style);
  endproperty
  a_tx_int: assert property (p_tx_int) else $error("tx interrupt level wrong");
  property p_soft_reset;
    @(posedge ref_clk_i) disable iff (!rstn_i)
    soft_rst |=> tx_cnt_q == '0 && lcr_q == REG_RST && dll_q == DLL_RST;
  endproperty
  a_soft_reset: assert property (p_soft_reset) else $error("reset pin not honoured");
  property p_spr_write;
    @(posedge ref_clk_i) disable iff (!rstn_i)
    wr_fall & (waddr_q == ADDR_SPR) & ~soft_rst |=> spr_q == $past(wdata_q);
  endproperty
  a_spr_write: assert property (p_spr_write) else $error("trailing edge write lost");
  property p_dir_read_no_write;
    @(posedge ref_clk_i) disable iff (!rstn_i)
    !pin_q.bus_style & pin_q.rw |-> !wr_act;
  endproperty
  a_dir_read_no_write: assert property (p_dir_read_no_write) else $error("write decoded on read");
  property p_fast_baud;
    @(posedge ref_clk_i) disable iff (!rstn_i)
    (divisor == 16'h0001 && !mcr_q[MCR_PRESCALE])[*3] |-> baud_tick_o;
  endproperty
  a_fast_baud: assert property (p_fast_baud) else $error("sample tick missing");

endmodule

//--- host_cpu_model.sv
module host_cpu_model
  import uart_host_bus_pkg::*;
(
  input wire logic ref_clk_i,
  input wire logic style_i, // 1 strobe bus, 0 direction bus
  input wire logic iso_i,
  input wire logic rst_i, // reset wanted, either style
  input wire logic [7:0] data_i,
  input wire logic data_oe_i,
  output uart_host_bus_pkg::host_pins_s pins_o
);
  timeunit 1ns;
  timeprecision 1ps;
  host_pins_s p; // bus cycle fields
  // style, isolation and reset polarity merged in
  always_comb begin
    pins_o = p;
    pins_o.bus_style = style_i;
    pins_o.bus_isolate_request = iso_i;
    pins_o.reset_pin = style_i ? rst_i : !rst_i;
  end
  initial begin
    p = '0;
    p.cs_n = 1'b1;
    p.read_strobe_n = 1'b1;
    p.write_strobe_n = 1'b1;
    p.rw = 1'b1;
  end
  // kind: 0 strobe write, 1 strobe read, 2 direction write, 3 direction read
  task automatic cyc(input logic [1:0] kind, input logic [2:0] a, input logic [7:0] d,
                     output logic [7:0] q, output logic ok);
    int n;
    n = 0;
    q = 8'h00;
    @(negedge ref_clk_i);
    p.addr = a;
    p.data = kind[0] ? ~d : d;
    p.cs_n = 1'b0;
    p.write_strobe_n = (kind != 2'h0);
    p.read_strobe_n = (kind != 2'h1);
    p.rw = (kind != 2'h2);
    if (kind[0]) begin
      // hold until the answer stands at a falling edge, bounded
      do begin
        @(negedge ref_clk_i);
        n++;
      end while (data_oe_i !== 1'b1 && n < 20);
      q = data_i;
    end else begin
      repeat (6) @(posedge ref_clk_i);
      @(negedge ref_clk_i);
    end
    ok = (data_oe_i === 1'b1) || !kind[0];
    p.cs_n = 1'b1;
    p.write_strobe_n = 1'b1;
    p.read_strobe_n = 1'b1;
    p.rw = 1'b1;
    p.data = ~p.data; // released bus shows no stale value
    repeat (8) @(negedge ref_clk_i);
  endtask
endmodule

//--- uart_host_bus_port_tb.sv
module uart_host_bus_port_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import uart_host_bus_pkg::*;
  localparam logic [7:0] ID = 8'hA7; // arbitrary value
  localparam logic [7:0] REV = 8'h2C; // arbitrary value
  logic ref_clk_i = 1'b0;
  logic rstn_i = 1'b0;
  logic style = 1'b1;
  logic iso = 1'b0;
  logic rst_pin = 1'b0;
  logic tx_ready_i = 1'b0;
  logic rx_valid_i = 1'b0;
  logic [7:0] rx_data_i = 8'h00;
  host_pins_s pins;
  logic [7:0] data_o, tx_data_o, q;
  logic data_oe_o, int_o, tx_valid_o, baud_tick_o, bit_tick_o, ok;
  int errors = 0;
  int checks_done = 0;
  int n;
  always #2.5 ref_clk_i = ~ref_clk_i;
  host_cpu_model i_host_cpu_model(.ref_clk_i, .style_i(style), .iso_i(iso), .rst_i(rst_pin),
    .data_i(data_o), .data_oe_i(data_oe_o), .pins_o(pins));
  uart_host_bus_port #(.DEVICE_ID(ID), .DEVICE_REV(REV)) i_uart_host_bus_port(.ref_clk_i, .rstn_i,
    .pins_i(pins), .data_o, .data_oe_o, .int_o, .tx_data_o, .tx_valid_o, .tx_ready_i, .rx_data_i,
    .rx_valid_i, .baud_tick_o, .bit_tick_o);
  task automatic end_sim();
    $display("checks %0d mismatches %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp) begin
      errors++;
      $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    i_host_cpu_model.cyc({~style, 1'b0}, a, d, q, ok);
  endtask
  task automatic rd(input logic [2:0] a, input logic [7:0] exp);
    i_host_cpu_model.cyc({~style, 1'b1}, a, 8'h00, q, ok);
    if (!ok) begin
      errors++;
      $display("MISMATCH t=%0t read timeout", $time);
      end_sim();
    end
    chk(q, exp);
  endtask
  task automatic pin_reset(input int cyc_n);
    @(negedge ref_clk_i);
    rst_pin = 1'b1;
    repeat (cyc_n) @(negedge ref_clk_i);
    rst_pin = 1'b0;
    repeat (8) @(negedge ref_clk_i);
  endtask
  task automatic push(input logic [7:0] d);
    @(negedge ref_clk_i);
    rx_data_i = d;
    rx_valid_i = 1'b1;
    @(negedge ref_clk_i);
    rx_valid_i = 1'b0;
    repeat (3) @(negedge ref_clk_i);
  endtask
  // cycles between two ticks of baud (sel 0) or bit (sel 1)
  task automatic period(input logic sel, input int exp);
    int w, gap;
    w = 0;
    gap = 0;
    // ticks are registered pulses, looked at where they stand
    do begin
      @(negedge ref_clk_i);
      w++;
    end while ((sel ? bit_tick_o : baud_tick_o) !== 1'b1 && w < 300);
    do begin
      @(negedge ref_clk_i);
      gap++;
    end while ((sel ? bit_tick_o : baud_tick_o) !== 1'b1 && gap < 300);
    if (w >= 300 || gap >= 300) begin
      errors++;
      $display("MISMATCH t=%0t tick timeout", $time);
      end_sim();
    end
    chk(gap[7:0], exp[7:0]);
    @(negedge ref_clk_i);
  endtask
  task automatic defaults();
    rd(ADDR_IER, 8'h00);
    rd(ADDR_ISR, 8'h01);
    rd(ADDR_MCR, 8'h00);
    rd(ADDR_LSR, 8'h60);
    rd(ADDR_MSR, 8'h00);
    rd(ADDR_SPR, 8'h00);
    wr(ADDR_LCR, 8'h80);
    rd(ADDR_DATA, 8'h01);
    rd(ADDR_IER, 8'h00);
    wr(ADDR_LCR, 8'h00);
    rd(ADDR_LCR, 8'h00);
  endtask
  initial begin
    repeat (6) @(negedge ref_clk_i);
    rstn_i = 1'b1;
    repeat (6) @(negedge ref_clk_i);
    defaults();
    $display("test defaults done");
    // identity codes, divisor and tick rates
    wr(ADDR_LCR, 8'h80);
    wr(ADDR_DATA, 8'h00);
    rd(ADDR_DATA, REV);
    rd(ADDR_IER, ID);
    wr(ADDR_DATA, 8'h02);
    rd(ADDR_DATA, 8'h02);
    rd(ADDR_IER, 8'h00);
    wr(ADDR_LCR, 8'h00);
    period(1'b0, 2);
    period(1'b1, 32);
    wr(ADDR_MCR, 8'h80);
    period(1'b0, 8);
    period(1'b1, 128);
    $display("test divisor done");
    // bus styles, wrong-style cycles, isolation
    wr(ADDR_SPR, 8'h3C);
    i_host_cpu_model.cyc(2'h2, ADDR_SPR, 8'h11, q, ok);
    rd(ADDR_SPR, 8'h3C);
    style = 1'b0;
    repeat (8) @(negedge ref_clk_i);
    i_host_cpu_model.cyc(2'h0, ADDR_SPR, 8'h22, q, ok);
    rd(ADDR_SPR, 8'h3C);
    wr(ADDR_SPR, 8'h5A);
    rd(ADDR_SPR, 8'h5A);
    iso = 1'b1;
    wr(ADDR_SPR, 8'hC3);
    i_host_cpu_model.cyc(2'h3, ADDR_SPR, 8'h00, q, ok);
    chk({7'h00, ok}, 8'h00);
    iso = 1'b0;
    rd(ADDR_SPR, 8'h5A);
    $display("test styles done");
    // reset pin in both polarities, short glitch ignored
    pin_reset(1);
    rd(ADDR_SPR, 8'h5A);
    pin_reset(9);
    defaults();
    style = 1'b1;
    repeat (8) @(negedge ref_clk_i);
    wr(ADDR_SPR, 8'h77);
    pin_reset(9);
    defaults();
    $display("test reset done");
    // queued transmit: fill past depth while stalled, then drain
    wr(ADDR_ISR, 8'h01);
    wr(ADDR_IER, 8'h02);
    chk({7'h00, int_o}, 8'h01);
    // one byte moves on to the serialiser, sixteen fill the queue, the last is dropped
    for (int i = 0; i < 18; i++) wr(ADDR_DATA, 8'h10 + 8'(i));
    rd(ADDR_LSR, 8'h00);
    chk({7'h00, int_o}, 8'h00);
    chk(tx_data_o, 8'h10);
    tx_ready_i = 1'b1;
    n = 0;
    // a byte is taken at the rising edge after valid stands with ready high
    for (int c = 0; c < 100 && n < 17; c++) begin
      if (tx_valid_o === 1'b1) begin
        chk(tx_data_o, 8'h10 + 8'(n));
        n++;
      end
      @(negedge ref_clk_i);
    end
    if (n != 17) begin
      errors++;
      $display("MISMATCH t=%0t transmit drain timeout", $time);
      end_sim();
    end
    repeat (10) @(negedge ref_clk_i);
    chk({7'h00, tx_valid_o}, 8'h00);
    chk({7'h00, int_o}, 8'h01);
    $display("test tx queue done");
    // queued receive, trigger four, legacy dma bit set
    wr(ADDR_ISR, 8'h49);
    wr(ADDR_IER, 8'h01);
    for (int i = 0; i < 3; i++) push(8'hA0 + 8'(i));
    chk({7'h00, int_o}, 8'h00);
    push(8'hA3);
    chk({7'h00, int_o}, 8'h01);
    rd(ADDR_ISR, 8'hC4);
    for (int i = 0; i < 4; i++) rd(ADDR_DATA, 8'hA0 + 8'(i));
    chk({7'h00, int_o}, 8'h00);
    $display("test rx queue done");
    // unqueued, direction style: low-active pin
    style = 1'b0;
    repeat (8) @(negedge ref_clk_i);
    wr(ADDR_ISR, 8'h00);
    chk({7'h00, int_o}, 8'h01);
    push(8'hB0);
    push(8'hB1);
    chk({7'h00, int_o}, 8'h00);
    rd(ADDR_DATA, 8'hB0);
    rd(ADDR_LSR, 8'h62);
    chk({7'h00, int_o}, 8'h01);
    wr(ADDR_IER, 8'h02);
    chk({7'h00, int_o}, 8'h00);
    $display("test unqueued done");
    end_sim();
  end
endmodule
